// >>> rtl/ppm_pilot_pwm.sv
// pilot pwm generator with midpoint adc trigger and supply-side state sequence
//
// What this block does
// - pulse train runs at fixed 1 kHz
// - fault or error holds pilot constantly low
// - idle ready state A holds pilot high
// - nine-volt band means vehicle connected, state B
// - six-volt band means ready, state C
// - three-volt band state D not supported
// - error state E not supported
// - pulse train starts once vehicle ready
// - higher duty encodes only current rating
// - nine-volt return while pulsing stops pulses
// - disconnect back to high level, state A
// - period starts at minus half tick count
// - output rises at negative rise compare
// - counter crossing zero emits midpoint trigger
// - output falls at fall compare
// - period end compare reloads start value
// - duty changes only via rise/fall compares
// - duty limited to three..ninety-seven percent
// - midpoint trigger goes out toward adc router
// - trigger only when trigger control bit0 set
// - new compares load only at period end or on entry to state C
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module ppm_pilot_pwm
  import ppm_pkg::*;
#(
  parameter int HALF_CNT = HALF_TICKS
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // sensed pilot line level
  input wire logic [LEVEL_W-1:0] pilot_line_level_in,
  input wire logic level_valid_in,
  // pilot drive, trigger and link state
  output logic pilot_pulse_out,
  output logic midpoint_trigger_out,
  output logic [1:0] pilot_state_out
);

  // counter bounds, derived from the half period
  localparam logic signed [CNT_W-1:0] CNT_START = CNT_W'(-HALF_CNT);
  localparam logic signed [CNT_W-1:0] CNT_END = CNT_W'(HALF_CNT);
  localparam logic signed [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CNT - 1);
  // rise and fall limits give 3..97 percent duty
  localparam logic signed [CNT_W-1:0] RISE_LO = CNT_W'(-(HALF_CNT * DUTY_MAX_PCT) / 100);
  localparam logic signed [CNT_W-1:0] RISE_HI = CNT_W'(-(HALF_CNT * DUTY_MIN_PCT) / 100);
  localparam logic signed [CNT_W-1:0] FALL_LO = CNT_W'((HALF_CNT * DUTY_MIN_PCT) / 100);
  localparam logic signed [CNT_W-1:0] FALL_HI = CNT_W'((HALF_CNT * DUTY_MAX_PCT) / 100);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

  // all state of the block
  typedef struct packed {
    logic en;                         // software enable
    logic fault_req;                  // software forced fault
    logic trig_en;                    // trigger control bit0
    logic signed [CNT_W-1:0] rise_w;  // rise compare, software copy
    logic signed [CNT_W-1:0] fall_w;  // fall compare, software copy
    logic signed [CNT_W-1:0] rise_a;  // rise compare in use
    logic signed [CNT_W-1:0] fall_a;  // fall compare in use
    logic signed [CNT_W-1:0] cnt;     // center-aligned counter
    logic [PRE_W-1:0] pre;            // bus clock prescaler
    ppm_state_t st;                   // pilot link state
    ppm_band_t band;                  // last sensed band
    logic err;                        // sticky unsupported-level flag
    logic pulse;                      // pilot drive level
    logic trig;                       // midpoint trigger pulse
    logic [DATA_W-1:0] rdata;         // read answer
  } ppm_regs_t;

  ppm_regs_t s_q;
  ppm_regs_t s_d;

  // map a sensed code to its voltage band
  function automatic ppm_band_t classify(input logic [LEVEL_W-1:0] lvl);
    if (lvl >= LVL_12V_MIN) begin
      classify = BAND_12V;
    end else if (lvl >= LVL_9V_MIN) begin
      classify = BAND_9V;
    end else if (lvl >= LVL_6V_MIN) begin
      classify = BAND_6V;
    end else if (lvl >= LVL_3V_MIN) begin
      classify = BAND_3V;
    end else begin
      classify = BAND_LOW;
    end
  endfunction

  // keep a compare inside its duty window
  function automatic logic signed [CNT_W-1:0] clamp(input logic signed [CNT_W-1:0] v,
      input logic signed [CNT_W-1:0] lo, input logic signed [CNT_W-1:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // next-state logic
  always_comb begin
    logic tick;
    logic signed [CNT_W-1:0] nxt;
    ppm_band_t b;
    tick = 1'b0;
    nxt = s_q.cnt;
    b = classify(pilot_line_level_in);
    s_d = s_q;
    s_d.trig = 1'b0;
    s_d.rdata = '0;
    // register writes
    if (wr_in) begin
      case (addr_in)
        ADDR_CTRL: begin
          s_d.en = wdata_in[CTRL_EN_BIT];
          s_d.fault_req = wdata_in[CTRL_FAULT_BIT];
        end
        ADDR_TRIG: begin
          s_d.trig_en = wdata_in[TRIG_MID_BIT];
        end
        ADDR_RISE: begin
          s_d.rise_w = wdata_in[CNT_W-1:0];
        end
        ADDR_FALL: begin
          s_d.fall_w = wdata_in[CNT_W-1:0];
        end
        ADDR_STAT: begin
          // write one clears the error flag
          if (wdata_in[STAT_ERR_BIT]) begin
            s_d.err = 1'b0;
          end
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // register reads, answered next cycle
    if (rd_in) begin
      case (addr_in)
        ADDR_CTRL: begin
          s_d.rdata[CTRL_EN_BIT] = s_q.en;
          s_d.rdata[CTRL_FAULT_BIT] = s_q.fault_req;
        end
        ADDR_TRIG: begin
          s_d.rdata[TRIG_MID_BIT] = s_q.trig_en;
        end
        ADDR_RISE: begin
          s_d.rdata = DATA_W'(s_q.rise_w);
        end
        ADDR_FALL: begin
          s_d.rdata = DATA_W'(s_q.fall_w);
        end
        ADDR_STAT: begin
          s_d.rdata[1:0] = s_q.st;
          s_d.rdata[STAT_PULSE_BIT] = s_q.pulse;
          s_d.rdata[STAT_ERR_BIT] = s_q.err;
          s_d.rdata[STAT_BAND_LSB +: 3] = s_q.band;
        end
        ADDR_CNT: begin
          s_d.rdata = DATA_W'(s_q.cnt);
        end
        default: begin
          // unmapped reads return zero
        end
      endcase
    end
    if (level_valid_in) begin
      s_d.band = b;
    end
    // link state sequence; only fresh samples move it out of A, B and C
    case (s_q.st)
      ST_FAULT: begin
        // leave once enabled and the error is acknowledged
        if (s_q.en && !s_q.fault_req && !s_q.err) begin
          s_d.st = ST_IDLE_A;
        end
      end
      ST_IDLE_A: begin
        if (level_valid_in && b == BAND_9V) begin
          s_d.st = ST_CONN_B;
        end
      end
      ST_CONN_B: begin
        if (level_valid_in && b == BAND_6V) begin
          s_d.st = ST_PULSE_C;
          s_d.cnt = CNT_START;
          s_d.pre = '0;
          s_d.pulse = 1'b0;
          s_d.rise_a = clamp(s_q.rise_w, RISE_LO, RISE_HI);
          s_d.fall_a = clamp(s_q.fall_w, FALL_LO, FALL_HI);
        end else if (level_valid_in && b == BAND_12V) begin
          s_d.st = ST_IDLE_A;
        end
      end
      ST_PULSE_C: begin
        tick = (s_q.pre == PRE_LAST);
        s_d.pre = tick ? '0 : s_q.pre + PRE_W'(1);
        if (tick) begin
          // step up by one tick, kept signed and full width
          nxt = s_q.cnt + CNT_W'(1);
          // reaching the end value reloads the start
          if (nxt == CNT_END) begin
            nxt = CNT_START;
            s_d.rise_a = clamp(s_q.rise_w, RISE_LO, RISE_HI);
            s_d.fall_a = clamp(s_q.fall_w, FALL_LO, FALL_HI);
          end
          s_d.cnt = nxt;
          if (nxt == s_q.rise_a) begin
            s_d.pulse = 1'b1;
          end else if (nxt == s_q.fall_a) begin
            s_d.pulse = 1'b0;
          end
          // midpoint of the high time, for the adc
          if (nxt == '0 && s_q.trig_en) begin
            s_d.trig = 1'b1;
          end
        end
        if (level_valid_in && b == BAND_9V) begin
          s_d.st = ST_CONN_B;
        end else if (level_valid_in && b == BAND_12V) begin
          s_d.st = ST_IDLE_A;
        end
      end
      default: begin
        s_d.st = ST_FAULT;
      end
    endcase
    // state D/E levels are not served: fault and flag
    if (level_valid_in && (b == BAND_3V || b == BAND_LOW) && s_q.st != ST_FAULT) begin
      s_d.err = 1'b1;
      s_d.st = ST_FAULT;
    end
    // software disable or forced fault wins
    if (!s_d.en || s_d.fault_req) begin
      s_d.st = ST_FAULT;
    end
    // drive level follows state; pulses only in C
    if (s_d.st != ST_PULSE_C) begin
      s_d.pulse = (s_d.st != ST_FAULT);
      s_d.trig = 1'b0;
      s_d.cnt = CNT_START;
      s_d.pre = '0;
    end
  end

  // the only register process; ce freezes everything
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '{en: 1'b0, fault_req: 1'b0, trig_en: 1'b0,
               rise_w: RISE_RST, fall_w: FALL_RST,
               rise_a: RISE_RST, fall_a: FALL_RST,
               cnt: CNT_START, pre: '0, st: ST_FAULT,
               band: BAND_LOW, err: 1'b0, pulse: 1'b0,
               trig: 1'b0, rdata: '0};
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rdata_out = s_q.rdata;
  assign pilot_pulse_out = s_q.pulse;
  assign midpoint_trigger_out = s_q.trig;
  assign pilot_state_out = s_q.st;

  // fault state keeps the line low
  AST_FAULT_LOW: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_FAULT) |-> !pilot_pulse_out)
    else $error("pilot not low in fault");

  // idle and connected states hold the line high
  AST_IDLE_HIGH: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_IDLE_A || s_q.st == ST_CONN_B) |-> pilot_pulse_out)
    else $error("pilot not high while idle");

  // nine-volt sample in A moves to B
  AST_CONNECT: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st == ST_IDLE_A && level_valid_in && pilot_line_level_in >= LVL_9V_MIN
     && pilot_line_level_in < LVL_12V_MIN && s_q.en && !s_q.fault_req && !wr_in)
    |=> (s_q.st == ST_CONN_B))
    else $error("connect not detected");

  // six-volt sample in B starts pulsing from the start value
  AST_START: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st == ST_CONN_B && level_valid_in && pilot_line_level_in >= LVL_6V_MIN
     && pilot_line_level_in < LVL_9V_MIN && s_q.en && !s_q.fault_req && !wr_in)
    |=> (s_q.st == ST_PULSE_C && s_q.cnt == CNT_START && !pilot_pulse_out))
    else $error("pulse train did not start");

  // nine-volt sample while pulsing stops the train
  AST_STOP: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st == ST_PULSE_C && level_valid_in && pilot_line_level_in >= LVL_9V_MIN
     && pilot_line_level_in < LVL_12V_MIN && s_q.en && !s_q.fault_req && !wr_in)
    |=> (s_q.st == ST_CONN_B && pilot_pulse_out))
    else $error("pulse train did not stop");

  // twelve-volt sample while connected returns to A
  AST_DISCONNECT: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st != ST_FAULT && s_q.st != ST_IDLE_A && level_valid_in
     && pilot_line_level_in >= LVL_12V_MIN && s_q.en && !s_q.fault_req && !wr_in)
    |=> (s_q.st == ST_IDLE_A))
    else $error("disconnect not seen");

  // last count of a period reloads the start value
  AST_RELOAD: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st == ST_PULSE_C && s_q.cnt == CNT_LAST && s_q.pre == PRE_LAST
     && !level_valid_in && s_q.en && !s_q.fault_req && !wr_in)
    |=> (s_q.cnt == CNT_START))
    else $error("counter not reloaded at period end");

  // the line rises exactly at the rise compare
  AST_RISE: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_PULSE_C && $rose(pilot_pulse_out)) |-> (s_q.cnt == s_q.rise_a))
    else $error("rise at wrong count");

  // the line falls exactly at the fall compare
  AST_FALL: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_PULSE_C && $past(s_q.st) == ST_PULSE_C && $fell(pilot_pulse_out))
    |-> (s_q.cnt == s_q.fall_a))
    else $error("fall at wrong count");

  // trigger is one cycle, at count zero, only when enabled
  AST_TRIGGER: assert property (@(posedge clk_in) disable iff (reset_in)
    midpoint_trigger_out |-> (s_q.cnt == '0 && $past(s_q.trig_en)) ##1 !midpoint_trigger_out)
    else $error("bad midpoint trigger");

  // compares in use change only at period end or on entry
  AST_SHADOW: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_PULSE_C && $past(s_q.st) == ST_PULSE_C && ($changed(s_q.rise_a) || $changed(s_q.fall_a)))
    |-> (s_q.cnt == CNT_START))
    else $error("compare loaded mid period");

  // compares in use stay in the duty window
  AST_DUTY: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == ST_PULSE_C) |-> (s_q.rise_a >= RISE_LO && s_q.rise_a <= RISE_HI
     && s_q.fall_a >= FALL_LO && s_q.fall_a <= FALL_HI))
    else $error("duty out of range");

  // a level below the six-volt band is refused: fault plus sticky flag
  AST_UNSUPPORTED: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && s_q.st != ST_FAULT && level_valid_in && pilot_line_level_in < LVL_6V_MIN)
    |=> (s_q.st == ST_FAULT && s_q.err))
    else $error("unsupported level not refused");

  // the trigger lands inside the high time, where the adc wants it
  AST_TRIG_HIGH: assert property (@(posedge clk_in) disable iff (reset_in)
    midpoint_trigger_out |-> pilot_pulse_out)
    else $error("trigger outside high time");

  // read data stand for one cycle only
  AST_READ_ONCE: assert property (@(posedge clk_in) disable iff (reset_in)
    (ce_in && !rd_in) |=> (rdata_out == '0))
    else $error("read data held too long");

  // ce low freezes the counter, the drive and the state
  AST_FREEZE: assert property (@(posedge clk_in) disable iff (reset_in)
    !ce_in |=> ($stable(s_q.cnt) && $stable(pilot_pulse_out) && $stable(pilot_state_out)))
    else $error("state moved while frozen");

endmodule

// >>> rtl/ppm_pkg.sv
// constants and types for the pilot pwm with midpoint trigger
package ppm_pkg;
  // timing: bus clock, prescaler, pilot period
  localparam int CLK_PERIOD_NS = 10;
  localparam int PILOT_FREQ_HZ = 1000;
  localparam int PILOT_PERIOD_NS = 1000000000 / PILOT_FREQ_HZ;
  localparam int PRESCALE = 4;
  localparam int PERIOD_TICKS = PILOT_PERIOD_NS / (CLK_PERIOD_NS * PRESCALE);
  localparam int HALF_TICKS = PERIOD_TICKS / 2;
  localparam int DUTY_MIN_PCT = 3;
  localparam int DUTY_MAX_PCT = 97;
  // widths
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int LEVEL_W = 16;
  localparam int PRE_W = 2;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TRIG = 4'h1;
  localparam logic [3:0] ADDR_RISE = 4'h2;
  localparam logic [3:0] ADDR_FALL = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_CNT = 4'h5;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FAULT_BIT = 1;
  localparam int TRIG_MID_BIT = 0;
  localparam int STAT_PULSE_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam int STAT_BAND_LSB = 4;
  // reset values
  localparam logic [15:0] RISE_RST = 16'hFB1E;
  localparam logic [15:0] FALL_RST = 16'h04E2;
  // level band thresholds on the sensed pilot code
  localparam logic [15:0] LVL_12V_MIN = 16'hD000;
  localparam logic [15:0] LVL_9V_MIN = 16'hA000;
  localparam logic [15:0] LVL_6V_MIN = 16'h7000;
  localparam logic [15:0] LVL_3V_MIN = 16'h4000;
  // pilot link states and measured level bands
  typedef enum logic [1:0] {ST_FAULT, ST_IDLE_A, ST_CONN_B, ST_PULSE_C} ppm_state_t;
  typedef enum logic [2:0] {BAND_12V, BAND_9V, BAND_6V, BAND_3V, BAND_LOW} ppm_band_t;
endpackage

// >>> testbench/ppm_vehicle_model.sv
// vehicle-side pilot sense model: resistor ladder bands and pulse timing meter
`timescale 1ns/10ps
module ppm_vehicle_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // pilot drive from the supply side
  input wire logic pilot_pulse_in,
  // vehicle switches
  input wire logic connected_in,
  input wire logic ready_switch_in,
  input wire logic ventilated_ready_switch_in,
  // sensed level toward the supply side
  output logic [15:0] level_out,
  output logic level_valid_out,
  // measured pulse timing in clocks, and rise count
  output logic [31:0] period_out,
  output logic [31:0] high_out,
  output logic [31:0] rises_out
);
  logic [31:0] since_q; // clocks since last rise
  logic [2:0] div_q; // sample pacing
  logic prev_q; // pilot drive one clock ago
  // connect and ready each pull the high level one band down; ventilated ready gives the three-volt band
  always_comb begin
    if (!pilot_pulse_in) begin
      level_out = 16'h0800;
    end else if (!connected_in) begin
      level_out = 16'hE000;
    end else if (ventilated_ready_switch_in) begin
      level_out = 16'h5000;
    end else if (ready_switch_in) begin
      level_out = 16'h8000;
    end else begin
      level_out = 16'hB000;
    end
  end
  // sample only inside a settled high phase, so the low half never looks like a fault
  assign level_valid_out = pilot_pulse_in && prev_q && (div_q == 3'h0);
  // meter rise-to-rise and rise-to-fall in clocks
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      since_q <= 32'h0000_0000;
      div_q <= 3'h0;
      prev_q <= 1'b0;
      period_out <= 32'h0000_0000;
      high_out <= 32'h0000_0000;
      rises_out <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 3'h1;
      prev_q <= pilot_pulse_in;
      since_q <= since_q + 32'h0000_0001;
      if (pilot_pulse_in && !prev_q) begin
        period_out <= since_q;
        since_q <= 32'h0000_0001;
        rises_out <= rises_out + 32'h0000_0001;
      end
      if (!pilot_pulse_in && prev_q) begin
        high_out <= since_q;
      end
    end
  end
endmodule

// >>> testbench/ppm_pilot_pwm_tb.sv
// self-checking bench for the pilot pwm with midpoint trigger
`timescale 1ns/10ps
module ppm_pilot_pwm_tb;
  import ppm_pkg::*;
  logic clk_in, reset_in, wr_in, rd_in, level_valid, pilot_pulse_out, midpoint_trigger_out;
  logic connected, ready_sw, vent_sw, pulse_prev, ce;
  logic [3:0] addr_in;
  logic [31:0] wdata_in, rdata_out, period, high, rises, since, trig_delay, trig_count, d;
  logic [15:0] level;
  logic [1:0] pilot_state_out;
  int failures, num_checks;
  // short half period keeps one pilot period at 400 clocks
  ppm_pilot_pwm #(.HALF_CNT(50)) ppm_pilot_pwm_inst (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pilot_line_level_in(level), .level_valid_in(level_valid),
    .pilot_pulse_out(pilot_pulse_out), .midpoint_trigger_out(midpoint_trigger_out),
    .pilot_state_out(pilot_state_out));
  ppm_vehicle_model ppm_vehicle_model_inst (.clk_in(clk_in), .reset_in(reset_in),
    .pilot_pulse_in(pilot_pulse_out), .connected_in(connected), .ready_switch_in(ready_sw),
    .ventilated_ready_switch_in(vent_sw), .level_out(level), .level_valid_out(level_valid),
    .period_out(period), .high_out(high), .rises_out(rises));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // clocks from pulse rise to the trigger, and trigger count
  always @(posedge clk_in) begin
    pulse_prev <= pilot_pulse_out;
    since <= (pilot_pulse_out && !pulse_prev) ? 32'h0000_0001 : since + 32'h0000_0001;
    if (reset_in) begin
      trig_count <= 32'h0000_0000;
    end else if (midpoint_trigger_out) begin
      trig_delay <= since;
      trig_count <= trig_count + 32'h0000_0001;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one-cycle bus strobes
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // bounded waits; running out counts a mismatch and ends the run
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (pilot_state_out !== s && n < 2000) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 2000) begin
      failures++;
      tally_and_finish();
    end
    #1 check(pilot_state_out, s, "state");
  endtask
  task automatic wait_rises(input int k);
    logic [31:0] goal;
    int n;
    goal = rises + k;
    n = 0;
    while (rises !== goal && n < 5000) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 5000) begin
      failures++;
      tally_and_finish();
    end
    #1;
  endtask
  task automatic t_reset();
    check(pilot_state_out, 2'h0, "reset state");
    check(pilot_pulse_out, 1'b0, "reset drive");
    rd(4'hF, d);
    check(d, 32'h0000_0000, "unmapped read");
    rd(ADDR_RISE, d);
    check(d, 32'hFFFF_FB1E, "rise reset");
    rd(ADDR_FALL, d);
    check(d, 32'h0000_04E2, "fall reset");
  endtask
  task automatic t_idle();
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_state(2'h1);
    check(pilot_pulse_out, 1'b1, "idle high");
    rd(ADDR_CTRL, d);
    check(d, 32'h0000_0001, "ctrl readback");
    // a write that meets ce low is lost
    @(posedge clk_in);
    ce <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0000);
    ce <= 1'b1;
    rd(ADDR_CTRL, d);
    check(d, 32'h0000_0001, "write lost while frozen");
    check(pilot_state_out, 2'h1, "frozen state");
    rd(ADDR_STAT, d);
    check(d & 32'h0000_000F, 32'h0000_0005, "idle status");
  endtask
  // ventilated request is unsupported and lands in fault
  task automatic t_vent();
    connected <= 1'b1;
    vent_sw <= 1'b1;
    wait_state(2'h0);
    check(pilot_pulse_out, 1'b0, "fault low");
    rd(ADDR_STAT, d);
    check(d & 32'h0000_000F, 32'h0000_0008, "fault status");
    vent_sw <= 1'b0;
    connected <= 1'b0;
    wr(ADDR_STAT, 32'h0000_0008);
    wait_state(2'h1);
  endtask
  task automatic t_pulse();
    connected <= 1'b1;
    wait_state(2'h2);
    check(pilot_pulse_out, 1'b1, "connected high");
    wr(ADDR_RISE, 32'h0000_FFF6);
    wr(ADDR_FALL, 32'h0000_000A);
    ready_sw <= 1'b1;
    wait_state(2'h3);
    wait_rises(2);
    check(period, 32'd400, "period");
    check(high, 32'd80, "high time");
    check(trig_count, 32'h0000_0000, "trigger off");
    wr(ADDR_TRIG, 32'h0000_0001);
    rd(ADDR_TRIG, d);
    check(d, 32'h0000_0001, "trigger control readback");
    wait_rises(2);
    check(trig_delay, 32'd40, "trigger mid high");
    // new compares written just after a rise wait for the wrap
    wait_rises(1);
    wr(ADDR_RISE, 32'h0000_FFE2);
    wr(ADDR_FALL, 32'h0000_001E);
    wait_rises(1);
    check(high, 32'd80, "old high kept");
    check(period, 32'd320, "reload at wrap");
    wait_rises(1);
    check(period, 32'd400, "period fixed");
    check(high, 32'd240, "new high");
    check(trig_delay, 32'd120, "new trigger");
  endtask
  task automatic t_stop();
    ready_sw <= 1'b0;
    wait_state(2'h2);
    repeat (8) @(posedge clk_in);
    #1 check(pilot_pulse_out, 1'b1, "pulses stopped");
    rd(ADDR_CNT, d);
    check(d, 32'hFFFF_FFCE, "counter parked at start");
    connected <= 1'b0;
    wait_state(2'h1);
    wr(ADDR_CTRL, 32'h0000_0003);
    wait_state(2'h0);
    check(pilot_pulse_out, 1'b0, "forced low");
  endtask
  initial begin
    failures = 0;
    num_checks = 0;
    reset_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 32'h0000_0000;
    connected = 1'b0;
    ready_sw = 1'b0;
    vent_sw = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1 t_reset();
    t_idle();
    t_vent();
    t_pulse();
    t_stop();
    tally_and_finish();
  end
endmodule
